// [dv/dac_double_buffer_interface_bench.sv]
// Self-checking bench for the converter host with a device model.
// Assumes dacbuf_host and dacbuf_dev_model are compiled before it.
`timescale 1ns/10ps
`default_nettype none
module dac_double_buffer_interface_bench;
  logic                    clk = 1'b0;       // 50 MHz clock
  logic                    rst = 1'b1;       // Held for 12 cycles
  logic                    req_valid = 1'b0; // Request offered
  dacbuf_pkg::dacbuf_req_t req = '0;         // Command and code
  logic                    req_ready;        // Host idle
  logic                    done;             // End of request
  dacbuf_pkg::dacbuf_pins_t pins;            // Device pins
  logic [15:0]             stage, code;      // Model latches
  int                      level_uv;         // Model output
  int                      mismatches = 0;   // Failed compares
  int                      tests_run = 0;    // All compares
  always #10 clk = ~clk;
  dacbuf_host i_dut (.CLK(clk), .RST(rst), .REQ_VALID(req_valid),
    .REQ(req), .REQ_READY(req_ready), .DONE(done), .PINS(pins));
  dacbuf_dev_model i_dev (.pins(pins), .stage(stage), .code(code),
    .level_uv(level_uv));
  // Counts and verdict, the single exit of the run
  task automatic summarize;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One request; checks latency, strobe and clear widths sampled after edges
  task automatic send(input logic [1:0] c, input logic [15:0] d,
                      input int lat, input int wl, input int cl);
    int n, w, k;
    n = 0; w = 0; k = 0;
    @(posedge clk);
    req_valid <= 1'b1;
    req <= dacbuf_pkg::dacbuf_req_t'({c, d});
    @(posedge clk);
    req_valid <= 1'b0;
    // Pins launched by the taking edge already count as the first cycle
    #1;
    w = int'(pins.write_n === 1'b0);
    k = int'(pins.midscale_clear_n === 1'b0);
    while (n < 20 && done !== 1'b1) begin
      @(posedge clk);
      #1;
      n++;
      w += int'(pins.write_n === 1'b0);
      k += int'(pins.midscale_clear_n === 1'b0);
    end
    if (n >= 20) begin
      mismatches++;
      $display("[ERR] %0t request never completed", $time);
      summarize();
    end
    // DONE shows after edge n past the taking edge and is sampled just after it; the taking edge makes n + 1
    check(n + 1, lat);
    check(w, wl);
    check(k, cl);
  endtask
  task automatic t_reset;
    check({pins.input_latch_enable_n, pins.converter_latch_enable_n,
      pins.write_n, pins.midscale_clear_n}, 4'hf);
    check(req_ready, 1'b1);
    $display("test reset done");
  endtask
  task automatic t_clear;
    send(2'h3, 16'h1234, 12, 0, 10);
    check(stage, 16'h0000);
    check(code, 16'h0000);
    $display("test clear done");
  endtask
  // Load first stage only, then transfer; bus word differs on transfer
  task automatic t_double;
    send(2'h0, 16'h7fff, 6, 3, 0);
    check(stage, 16'h7fff);
    check(code, 16'h0000);
    send(2'h1, 16'h0000, 6, 3, 0);
    check(code, 16'h7fff);
    check(stage, 16'h7fff);
    check(level_uv, 5000000 + 32767 * 152);
    $display("test double done");
  endtask
  task automatic t_single;
    send(2'h2, 16'h8000, 7, 4, 0);
    check(code, 16'h8000);
    check(stage, 16'h8000);
    $display("test single done");
  endtask
  // Clear after loaded stages must wipe both
  task automatic t_override;
    send(2'h0, 16'hffff, 6, 3, 0);
    send(2'h3, 16'hffff, 12, 0, 10);
    check(stage, 16'h0000);
    check(code, 16'h0000);
    $display("test override done");
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    t_reset();
    t_clear();
    t_double();
    t_single();
    t_override();
    summarize();
  end
endmodule
`default_nettype wire

// [dv/dacbuf_dev_model.sv]
// Behavioural model of the double-buffered converter front end.
// Assumes the host drives the pin struct straight, with no clock.
`timescale 1ns/10ps
`default_nettype none
module dacbuf_dev_model (
  input  wire dacbuf_pkg::dacbuf_pins_t pins,     // Pins from host
  output logic [15:0]                   stage,    // First-stage latch
  output logic [15:0]                   code,     // Converter latch
  output int                            level_uv  // Output in microvolts
);
  // Anything not driven high reads as asserted, so a floating pin acts low
  logic clr_on;  // Clear asserted
  logic wr_on;   // Strobe asserted
  assign clr_on = pins.midscale_clear_n !== 1'b1;
  assign wr_on  = pins.write_n !== 1'b1;
  // First stage follows the bus while open, holds once closed
  always_latch begin
    if (clr_on) begin
      stage <= 16'h0000;
    end else if (wr_on && pins.input_latch_enable_n !== 1'b1) begin
      stage <= pins.data;
    end
  end
  // Converter latch takes the first stage, so both open means pass-through
  always_latch begin
    if (clr_on) begin
      code <= 16'h0000;
    end else if (wr_on && pins.converter_latch_enable_n !== 1'b1) begin
      code <= stage;
    end
  end
  // Signed code around half scale; the step is rounded, so ends drift
  assign level_uv = 5000000 + 152 * int'($signed(code));
endmodule
`default_nettype wire

// [rtl/dacbuf_cfg.svh]
// Timing counts and codes for the double-buffered converter host.
// Assumes a 50 MHz CLK; included by the host module.
`ifndef DACBUF_CFG_SVH
`define DACBUF_CFG_SVH
`define DACBUF_CLK_NS        20
`define DACBUF_SETUP_NS      50
`define DACBUF_HOLD_NS       10
`define DACBUF_WP_NS         50
`define DACBUF_WP_SINGLE_NS  80
`define DACBUF_CLR_NS        200
`define DACBUF_CYC(ns)       (((ns) + `DACBUF_CLK_NS - 1) / `DACBUF_CLK_NS)
`define DACBUF_MIDSCALE      16'h0000
`endif

// [rtl/dacbuf_host.sv]
// Host controller driving the double-buffered 16-bit converter pins.
// Assumes the pins wire straight to the device; one request at a time.
// Operation
// - Latch opens when strobe and enable low.
// - Load inputs separately, then transfer all together.
// - Single-buffered mode holds enables low.
// - Single-buffered strobe low at least 80 ns.
// - All low with clear high passes through.
`timescale 1ns/10ps
`default_nettype none
`include "dacbuf_cfg.svh"
module dacbuf_host #(
  parameter int WIDTH = 16 // Converter word width
) (
  input  wire logic                 CLK,      // 50 MHz clock
  input  wire logic                 RST,      // Sync reset, active high
  input  wire logic                 REQ_VALID,// Request offered
  input  wire dacbuf_pkg::dacbuf_req_t REQ,   // Command and code
  output logic                      REQ_READY,// Sequencer idle
  output logic                      DONE,     // Pulse at request end
  output dacbuf_pkg::dacbuf_pins_t  PINS      // Device pins
);
  localparam int SETUP_CYC = `DACBUF_CYC(`DACBUF_SETUP_NS);
  localparam int HOLD_CYC  = `DACBUF_CYC(`DACBUF_HOLD_NS);
  localparam int WP_CYC    = `DACBUF_CYC(`DACBUF_WP_NS);
  localparam int WPS_CYC   = `DACBUF_CYC(`DACBUF_WP_SINGLE_NS);
  localparam int CLR_CYC   = `DACBUF_CYC(`DACBUF_CLR_NS);

  // Whole module state in one packed struct
  typedef struct packed {
    dacbuf_pkg::dacbuf_state_t st;   // Sequencer state
    logic [3:0]                cnt;  // Cycles left in the phase
    dacbuf_pkg::dacbuf_cmd_t   cmd;  // Command in flight
    dacbuf_pkg::dacbuf_pins_t  pins; // Registered pin levels
    logic                      done; // End-of-request pulse
  } dacbuf_host_state_t;

  dacbuf_host_state_t s;      // Current state
  dacbuf_host_state_t next_s; // Next state

  // Parked pins: enables, strobe and clear high, code as passed in
  function automatic dacbuf_pkg::dacbuf_pins_t park(input logic [WIDTH-1:0] d);
    dacbuf_pkg::dacbuf_pins_t p;
    p.data                     = d;
    p.input_latch_enable_n     = 1'b1;
    p.converter_latch_enable_n = 1'b1;
    p.write_n                  = 1'b1;
    p.midscale_clear_n         = 1'b1;
    return p;
  endfunction

  // Phase length minus one, cut to the counter width
  function automatic logic [3:0] len(input int c);
    return 4'((c > 0) ? c - 1 : 0);
  endfunction

  assign REQ_READY = (s.st == dacbuf_pkg::DACBUF_IDLE);
  assign DONE      = s.done;
  assign PINS      = s.pins;

  // Sequencer: setup, strobe, hold; clear skips data timing
  always_comb begin
    next_s      = s;
    next_s.done = 1'b0;
    case (s.st)
      dacbuf_pkg::DACBUF_IDLE: begin
        if (REQ_VALID) begin
          next_s.cmd       = REQ.cmd;
          next_s.pins.data = REQ.data;
          case (REQ.cmd)
            dacbuf_pkg::DACBUF_CMD_INPUT: begin
              next_s.pins.input_latch_enable_n = 1'b0;
            end
            dacbuf_pkg::DACBUF_CMD_CONV: begin
              // Shared transfer for simultaneous update
              next_s.pins.converter_latch_enable_n = 1'b0;
            end
            dacbuf_pkg::DACBUF_CMD_SINGLE: begin
              next_s.pins.input_latch_enable_n     = 1'b0;
              next_s.pins.converter_latch_enable_n = 1'b0;
            end
            default: begin
              // Clear needs no enables; it overrides them
              next_s.pins.data = `DACBUF_MIDSCALE;
            end
          endcase
          if (REQ.cmd == dacbuf_pkg::DACBUF_CMD_CLEAR) begin
            next_s.st = dacbuf_pkg::DACBUF_PULSE;
            next_s.cnt = len(CLR_CYC);
            next_s.pins.midscale_clear_n = 1'b0;
          end else begin
            next_s.st  = dacbuf_pkg::DACBUF_SETUP;
            next_s.cnt = len(SETUP_CYC - WP_CYC);
          end
        end
      end
      dacbuf_pkg::DACBUF_SETUP: begin
        // Strobe drops; setup overlaps the strobe width
        if (s.cnt == 4'h0) begin
          next_s.st = dacbuf_pkg::DACBUF_PULSE;
          next_s.pins.write_n = 1'b0;
          next_s.cnt = (s.cmd == dacbuf_pkg::DACBUF_CMD_SINGLE) ?
                       len(WPS_CYC) : len(WP_CYC);
        end else begin
          next_s.cnt = s.cnt - 4'h1;
        end
      end
      dacbuf_pkg::DACBUF_PULSE: begin
        if (s.cnt == 4'h0) begin
          next_s.pins.write_n          = 1'b1;
          next_s.pins.midscale_clear_n = 1'b1;
          next_s.st  = dacbuf_pkg::DACBUF_HOLD;
          next_s.cnt = len(HOLD_CYC);
        end else begin
          next_s.cnt = s.cnt - 4'h1;
        end
      end
      dacbuf_pkg::DACBUF_HOLD: begin
        if (s.cnt == 4'h0) begin
          next_s.pins = park(s.pins.data);
          next_s.st   = dacbuf_pkg::DACBUF_IDLE;
          next_s.done = 1'b1;
        end else begin
          next_s.cnt = s.cnt - 4'h1;
        end
      end
      default: begin
        next_s.st   = dacbuf_pkg::DACBUF_IDLE;
        next_s.pins = park(`DACBUF_MIDSCALE);
      end
    endcase
  end

  // State register; control pins parked high and data at mid-scale from reset
  always_ff @(posedge CLK) begin
    if (RST) begin
      s.st   <= dacbuf_pkg::DACBUF_IDLE;
      s.cnt  <= 4'h0;
      s.cmd  <= dacbuf_pkg::DACBUF_CMD_INPUT;
      s.pins <= park(`DACBUF_MIDSCALE); // No unconnected input
      s.done <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  // Enables never both low outside a pass-through write
  enables_exclusive_a: assert property (
    @(posedge CLK) disable iff (RST)
    (!s.pins.input_latch_enable_n && !s.pins.converter_latch_enable_n)
    |-> s.cmd == dacbuf_pkg::DACBUF_CMD_SINGLE)
    else $error("both enables low outside single write");
  // Single-buffered strobe low for four cycles
  single_width_a: assert property (
    @(posedge CLK) disable iff (RST)
    ($fell(s.pins.write_n) && s.cmd == dacbuf_pkg::DACBUF_CMD_SINGLE)
    |-> !s.pins.write_n [*4])
    else $error("single write strobe too short");
  // Normal strobe low for three cycles
  write_width_a: assert property (@(posedge CLK) disable iff (RST)
    $fell(s.pins.write_n) |-> !s.pins.write_n [*3])
    else $error("write strobe too short");
  // Strobe only falls with an enable already low
  strobe_enable_a: assert property (
    @(posedge CLK) disable iff (RST)
    $fell(s.pins.write_n) |-> $past(!s.pins.input_latch_enable_n ||
                                    !s.pins.converter_latch_enable_n))
    else $error("strobe without enable");
  // Clear held ten cycles, with strobe high for the first eight
  clear_width_a: assert property (@(posedge CLK) disable iff (RST)
    $fell(s.pins.midscale_clear_n) |->
      (!s.pins.midscale_clear_n && s.pins.write_n) [*8] ##1
      (!s.pins.midscale_clear_n [*2]))
    else $error("clear pulse too short");
  // Enables stay low one cycle after strobe rises
  enable_hold_a: assert property (@(posedge CLK) disable iff (RST)
    ($rose(s.pins.write_n) && s.cmd != dacbuf_pkg::DACBUF_CMD_CLEAR) |->
      (!s.pins.input_latch_enable_n || !s.pins.converter_latch_enable_n))
    else $error("enable released with strobe");
  // Data stable through strobe
  data_stable_a: assert property (
    @(posedge CLK) disable iff (RST)
    !s.pins.write_n |-> $stable(s.pins.data))
    else $error("data moved under strobe");
  // Done follows an accepted request within twenty cycles
  done_bound_a: assert property (@(posedge CLK) disable iff (RST)
    (REQ_VALID && REQ_READY) |-> ##[3:20] DONE)
    else $error("request never completed");
  // Parked pins whenever the sequencer is idle, so no latch can open
  idle_parked_a: assert property (
    @(posedge CLK) disable iff (RST)
    REQ_READY |-> (s.pins.input_latch_enable_n &&
                   s.pins.converter_latch_enable_n &&
                   s.pins.write_n && s.pins.midscale_clear_n))
    else $error("pins not parked while idle");
  // Clear pulse carries no strobe and no enable, code at mid-scale
  clear_alone_a: assert property (
    @(posedge CLK) disable iff (RST)
    !s.pins.midscale_clear_n |-> (s.pins.write_n &&
      s.pins.input_latch_enable_n && s.pins.converter_latch_enable_n &&
      s.pins.data == `DACBUF_MIDSCALE))
    else $error("clear overlaps a write");
  // Input load strobes with the converter latch closed
  input_only_a: assert property (
    @(posedge CLK) disable iff (RST)
    (!s.pins.write_n && s.cmd == dacbuf_pkg::DACBUF_CMD_INPUT) |->
      (!s.pins.input_latch_enable_n && s.pins.converter_latch_enable_n))
    else $error("input load opens the wrong latch");
  // Transfer strobes with the input latch closed, so the stage is kept
  conv_only_a: assert property (
    @(posedge CLK) disable iff (RST)
    (!s.pins.write_n && s.cmd == dacbuf_pkg::DACBUF_CMD_CONV) |->
      (s.pins.input_latch_enable_n && !s.pins.converter_latch_enable_n))
    else $error("transfer opens the wrong latch");
  // Pass-through write: both enables and strobe low, clear high
  single_pass_a: assert property (
    @(posedge CLK) disable iff (RST)
    (!s.pins.write_n && s.cmd == dacbuf_pkg::DACBUF_CMD_SINGLE) |->
      (!s.pins.input_latch_enable_n && !s.pins.converter_latch_enable_n &&
       s.pins.midscale_clear_n))
    else $error("pass-through write lacks an enable");
endmodule
`default_nettype wire

// [rtl/dacbuf_pkg.sv]
// Types for the double-buffered converter host.
// Assumes dacbuf_cfg.svh sits beside it.
package dacbuf_pkg;
  // Host command kinds
  typedef enum logic [1:0] {
    DACBUF_CMD_INPUT  = 2'h0, // Load first-stage latch only
    DACBUF_CMD_CONV   = 2'h1, // Transfer first stage to converter latch
    DACBUF_CMD_SINGLE = 2'h2, // Both enables low, pass-through write
    DACBUF_CMD_CLEAR  = 2'h3  // Pulse clear to mid-scale
  } dacbuf_cmd_t;
  // Request carried in one beat
  typedef struct packed {
    dacbuf_cmd_t cmd;  // What to do
    logic [15:0] data; // Signed two's complement code
  } dacbuf_req_t;
  // Device pins, all active low except data
  typedef struct packed {
    logic [15:0] data;
    logic        input_latch_enable_n;
    logic        converter_latch_enable_n;
    logic        write_n;
    logic        midscale_clear_n;
  } dacbuf_pins_t;
  // One-hot sequencer states
  typedef enum logic [3:0] {
    DACBUF_IDLE  = 4'h1, // Pins parked, ready for a request
    DACBUF_SETUP = 4'h2, // Enables and data settle before strobe
    DACBUF_PULSE = 4'h4, // Strobe or clear held low
    DACBUF_HOLD  = 4'h8  // Enables and data held after strobe
  } dacbuf_state_t;
endpackage
